// file: src/iptpm_pkg.sv
package iptpm_pkg;

  // ----------------------------------------
  // Table geometry
  // ----------------------------------------
  localparam int unsigned IPTPM_ADDR_W = 8;
  localparam int unsigned IPTPM_DATA_W = 8;
  localparam int unsigned IPTPM_PRIO_W = 2;
  localparam int unsigned IPTPM_IDX_W = 6;
  localparam int unsigned IPTPM_ENTRIES_PER_REG = 4;
  localparam int unsigned IPTPM_NUM_REGS = 9;
  localparam int unsigned IPTPM_NUM_ENTRIES = IPTPM_NUM_REGS * IPTPM_ENTRIES_PER_REG;
  localparam int unsigned IPTPM_TOS_IDX_MSB = 7;
  localparam int unsigned IPTPM_TOS_IDX_LSB = 2;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] IP_PRIORITY_MAP_IDX00_03 = 8'h90;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX04_07 = 8'h91;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX08_0B = 8'h92;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX0C_0F = 8'h93;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX10_13 = 8'h94;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX14_17 = 8'h95;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX18_1B = 8'h96;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX1C_1F = 8'h97;
  localparam logic [7:0] IP_PRIORITY_MAP_IDX20_23 = 8'h98;
  localparam logic [7:0] IPTPM_TABLE_BASE = IP_PRIORITY_MAP_IDX00_03;

  // ----------------------------------------
  // Reset values and fixed answers
  // ----------------------------------------
  localparam logic [7:0] IPTPM_MAP_RESET = 8'h00;
  localparam logic [7:0] IPTPM_UNMAPPED_READ = 8'h00;
  localparam logic [1:0] IPTPM_PRIO_RESET = 2'h0;
  localparam logic [1:0] IPTPM_PRIO_UNCOVERED = 2'h0;
  localparam int unsigned IPTPM_LOOKUP_LATENCY = 1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic is_ipv4;
    logic is_ipv6;
    logic [7:0] tos;
    logic [1:0] fallback_prio;
  } iptpm_frame_type;

  typedef struct packed {
    logic valid;
    logic from_table;
    logic [1:0] prio;
  } iptpm_result_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iptpm_reg_req_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] rdata;
  } iptpm_reg_rsp_type;

endpackage

// file: src/iptpm_entry_select.sv
module iptpm_entry_select
  import iptpm_pkg::*;
#(
  parameter int unsigned NUM_REGS = IPTPM_NUM_REGS
) (
  // Flattened table, register 0 in the low byte
  input wire logic [NUM_REGS*8-1:0] table_flat,
  // Six-bit class index
  input wire logic [IPTPM_IDX_W-1:0] index,
  // Selected entry
  output logic [IPTPM_PRIO_W-1:0] entry,
  output logic covered
);

  // ----------------------------------------
  // Entry select
  // ----------------------------------------
  // Entry n sits at bits 2n+1:2n of the flat table, four to a byte
  localparam int unsigned ENTRIES = NUM_REGS * IPTPM_ENTRIES_PER_REG;

  wire [IPTPM_PRIO_W-1:0] entry_array [ENTRIES];

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_entry
      assign entry_array[g] = table_flat[g*2 +: 2];
    end
  endgenerate

  // Indices beyond the held table read as a fixed priority
  assign covered = (32'(index) < ENTRIES);
  assign entry = covered ? entry_array[index] : IPTPM_PRIO_UNCOVERED;

endmodule

// file: src/iptpm_top.sv
module iptpm_top
  import iptpm_pkg::*;
#(
  parameter int unsigned NUM_REGS = IPTPM_NUM_REGS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire iptpm_reg_req_type reg_req,
  output iptpm_reg_rsp_type reg_rsp,
  // Classification control
  input wire logic ip_prio_enable,
  // Frame side
  input wire iptpm_frame_type frame_in,
  output iptpm_result_type prio_out
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Returns the table slot for an address; valid only when in range
  function automatic logic [7:0] slot_of(input logic [7:0] addr);
    slot_of = addr - IPTPM_TABLE_BASE;
  endfunction

  function automatic logic in_table(input logic [7:0] addr);
    in_table = (addr >= IPTPM_TABLE_BASE) &&
               (32'(slot_of(addr)) < NUM_REGS);
  endfunction

  wire [7:0] wr_slot;
  wire [7:0] rd_slot;
  wire wr_hit;
  wire rd_hit;

  assign wr_slot = slot_of(reg_req.addr);
  assign rd_slot = slot_of(reg_req.addr);
  assign wr_hit = reg_req.wr && in_table(reg_req.addr);
  assign rd_hit = reg_req.rd && in_table(reg_req.addr);

  // ----------------------------------------
  // Priority map registers
  // ----------------------------------------
  // Slot 0 holds indices 0-3 and slot 8 indices 0x20-0x23, each byte
  // carries four entries with the lowest index in bits 1-0
  logic [7:0] map_reg [NUM_REGS];
  wire [NUM_REGS*8-1:0] table_flat;

  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_map
      wire this_wr;
      assign this_wr = wr_hit && (32'(wr_slot) == r);

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          map_reg[r] <= IPTPM_MAP_RESET;
        end else if (this_wr) begin
          map_reg[r] <= reg_req.wdata;
        end
      end

      // The lookup reads the live registers, so no shadow copy lags a write
      assign table_flat[r*8 +: 8] = map_reg[r];
    end
  endgenerate

  // ----------------------------------------
  // Register read path
  // ----------------------------------------
  wire [7:0] rd_value;
  wire [3:0] rd_index;

  assign rd_index = rd_slot[3:0];
  assign rd_value = rd_hit ? map_reg[rd_index] : IPTPM_UNMAPPED_READ;

  iptpm_reg_rsp_type next_reg_rsp;

  // One continuous assignment for the whole carrier keeps a single driver
  assign next_reg_rsp = '{valid: reg_req.rd, hit: rd_hit, rdata: rd_value};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp <= next_reg_rsp;
    end
  end

  // ----------------------------------------
  // Frame classification
  // ----------------------------------------
  wire [IPTPM_IDX_W-1:0] tos_index;
  wire [IPTPM_PRIO_W-1:0] table_entry;
  wire entry_covered;
  wire is_ip;
  wire use_table;

  assign tos_index = frame_in.tos[IPTPM_TOS_IDX_MSB:IPTPM_TOS_IDX_LSB];
  assign is_ip = frame_in.is_ipv4 || frame_in.is_ipv6;
  assign use_table = ip_prio_enable && is_ip;

  iptpm_entry_select #(
    .NUM_REGS(NUM_REGS)
  ) u_select (
    .table_flat(table_flat),
    .index(tos_index),
    .entry(table_entry),
    .covered(entry_covered)
  );

  // Non-IP frames and a disabled map keep the priority decided upstream
  iptpm_result_type next_prio_out;

  assign next_prio_out = '{
    valid: frame_in.valid,
    from_table: frame_in.valid && use_table,
    prio: !frame_in.valid ? IPTPM_PRIO_RESET :
          use_table ? table_entry : frame_in.fallback_prio
  };

  // One register stage, so the queue logic sees a stable priority
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prio_out <= '0;
    end else begin
      prio_out <= next_prio_out;
    end
  end

endmodule

// file: dv/iptpm_props.sv
module iptpm_props
  import iptpm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire iptpm_reg_req_type reg_req,
  input wire iptpm_reg_rsp_type reg_rsp,
  input wire logic ip_prio_enable,
  input wire iptpm_frame_type frame_in,
  input wire iptpm_result_type prio_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire mapped = reg_req.addr inside {[8'h90:8'h98]};
  wire use_tab = ip_prio_enable && (frame_in.is_ipv4 || frame_in.is_ipv6);
  // Write alone, then a read of the same place on the next edge
  sequence s_wr_rd;
    reg_req.wr && !reg_req.rd && mapped ##1 reg_req.rd && $stable(reg_req.addr);
  endsequence
  AST_RD_ANS: assert property (reg_req.rd |=> reg_rsp.valid) else $error("no answer");
  AST_RD_IDLE: assert property (!reg_req.rd |=> !reg_rsp.valid) else $error("stray answer");
  AST_HIT: assert property (reg_req.rd && mapped |=> reg_rsp.hit) else $error("miss");
  AST_UNMAP: assert property (reg_req.rd && !mapped
    |=> !reg_rsp.hit && reg_rsp.rdata == 8'h00) else $error("unmapped read");
  AST_WR_RD: assert property (s_wr_rd |=> reg_rsp.rdata == $past(reg_req.wdata, 2))
    else $error("write lost");
  AST_FRM: assert property (frame_in.valid |=> prio_out.valid) else $error("no result");
  AST_NOFRM: assert property (!frame_in.valid |=> !prio_out.valid && prio_out.prio == 2'h0)
    else $error("stray result");
  AST_FALLBK: assert property (frame_in.valid && !use_tab |=> !prio_out.from_table
    && prio_out.prio == $past(frame_in.fallback_prio)) else $error("fallback");
  AST_TAB: assert property (frame_in.valid && use_tab |=> prio_out.from_table)
    else $error("table unused");
  AST_UNCOV: assert property (frame_in.valid && use_tab && frame_in.tos[7:2] > 6'h23
    |=> prio_out.prio == 2'h0) else $error("uncovered index");
endmodule

bind iptpm_top iptpm_props u_props (.ref_clk, .rst, .reg_req, .reg_rsp, .ip_prio_enable,
  .frame_in, .prio_out);

// file: dv/tb.sv
module tb
  import iptpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0;
  logic rst = 1;
  logic ip_prio_enable = 0;
  iptpm_reg_req_type reg_req = '0;
  iptpm_reg_rsp_type reg_rsp;
  iptpm_frame_type frame_in = '0;
  iptpm_result_type prio_out;
  logic [7:0] m [9];
  int n_errors = 0;
  int samples_checked = 0;
  iptpm_top DUT (.ref_clk, .rst, .reg_req, .reg_rsp, .ip_prio_enable, .frame_in, .prio_out);
  always #12.5 ref_clk = ~ref_clk;
  // Inputs move 2 ns after the edge, so no race with the design's sampling
  task automatic tick;
    @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_req = '{1'b1, 1'b0, a, d};
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic h, input logic [7:0] e);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    tick;
    chk(reg_rsp, {1'b1, h, e});
  endtask
  task automatic fr(input logic v4, v6, input logic [7:0] t, input logic [1:0] fb,
    input logic ft, input logic [1:0] p);
    frame_in = '{1'b1, v4, v6, t, fb};
    tick;
    chk(prio_out, {1'b1, ft, p});
  endtask
  task automatic results;
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #2 rst = 0;
    tick;
    for (int i = 0; i < 9; i++) rd(8'h90 + i[7:0], 1'b1, 8'h00);
    rd(8'h8F, 1'b0, 8'h00);
    wr(8'h99, 8'hFF);
    rd(8'h99, 1'b0, 8'h00);
    for (int i = 0; i < 9; i++) begin
      m[i] = 8'hE4 ^ (i[7:0] * 8'h25);
      wr(8'h90 + i[7:0], m[i]);
    end
    for (int i = 0; i < 9; i++) rd(8'h90 + i[7:0], 1'b1, m[i]);
    ip_prio_enable = 1;
    for (int n = 0; n < 64; n++)
      fr(n[0], !n[0], {n[5:0], 2'b11}, 2'h1, 1'b1, n < 36 ? m[n/4][2*(n%4) +: 2] : 2'h0);
    fr(1'b0, 1'b0, 8'h00, 2'h3, 1'b0, 2'h3);
    fr(1'b1, 1'b1, 8'h04, 2'h3, 1'b1, m[0][3:2]);
    ip_prio_enable = 0;
    fr(1'b1, 1'b0, 8'h08, 2'h2, 1'b0, 2'h2);
    ip_prio_enable = 1;
    reg_req = '{1'b1, 1'b0, 8'h90, 8'h03};
    fr(1'b1, 1'b0, 8'h00, 2'h0, 1'b1, m[0][1:0]);
    fr(1'b1, 1'b0, 8'h00, 2'h0, 1'b1, 2'h3);
    reg_req = '0;
    frame_in = '0;
    tick;
    chk(prio_out, 16'h0000);
    wr(8'h93, 8'h5A);
    rd(8'h93, 1'b1, 8'h5A);
    rst = 1;
    tick;
    rst = 0;
    tick;
    rd(8'h91, 1'b1, 8'h00);
    rd(8'h93, 1'b1, 8'h00);
    results;
  end
endmodule
